//--- nvbl_map.svh
`ifndef NVBL_MAP_SVH
`define NVBL_MAP_SVH
// Word addresses in the non-volatile store
`define NVBL_ADDR_WORD_A 10'h30a
`define NVBL_ADDR_WORD_B 10'h30b
// Field positions
`define NVBL_BIT_FR 23
`define NVBL_BIT_LE 22
`define NVBL_BIT_LM 21
`define NVBL_BIT_DM 23
`define NVBL_BIT_GR 22
`define NVBL_BIT_LI 21
`define NVBL_LIM_HI 20
`define NVBL_LIM_LO 16
`define NVBL_DEN_HI 15
// Reset (erased-default) contents of the words
`define NVBL_RST_WORD_A 24'h1fec39
`define NVBL_RST_WORD_B 24'h402ee4
// Extended commands
`define NVBL_CMD_LOCKS 16'hfff8
`define NVBL_CMD_KEY 16'hfffe
// Field scale in gauss per step
`define NVBL_GAUSS_HI 11'd40
`define NVBL_GAUSS_LO 11'd20
`endif

//--- nvbl_pkg.sv
package nvbl_pkg;
    typedef logic [23:0] nvbl_word_type;
    typedef enum logic [3:0]
    {
        NVBL_BOOT = 4'h1,
        NVBL_LOAD = 4'h2,
        NVBL_IDLE = 4'h4,
        NVBL_RUN = 4'h8
    } nvbl_state_type;
endpackage

//--- nvbl_field_cmp.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvbl_map.svh"
module nvbl_field_cmp
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [10:0] field_gauss,
    input wire logic field_valid,
    input wire logic [4:0] upper_steps,
    input wire logic [4:0] lower_steps,
    output logic field_over_flag,
    output logic field_under_flag
);
    wire [10:0] upper_gauss;
    wire [10:0] lower_gauss;
    wire over_now;
    wire under_now;

    // Scale limits to gauss
    assign upper_gauss = 11'({6'h00, upper_steps} * `NVBL_GAUSS_HI);
    assign lower_gauss = 11'({6'h00, lower_steps} * `NVBL_GAUSS_LO);
    assign over_now = field_valid && (field_gauss > upper_gauss);
    assign under_now = field_valid && (field_gauss < lower_gauss);

    // Registered flags track each new sample
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            field_over_flag <= 1'b0;
            field_under_flag <= 1'b0;
        end
        else if (field_valid)
        begin
            field_over_flag <= over_now;
            field_under_flag <= under_now;
        end
    end
endmodule
`default_nettype wire

//--- nvbl_word_store.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvbl_map.svh"
module nvbl_word_store
    import nvbl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic erase_en,
    input wire logic idx,
    input wire nvbl_word_type wr_data,
    input wire logic locked,
    output nvbl_word_type word_a,
    output nvbl_word_type word_b,
    output logic refused
);
    nvbl_word_type mem_r [0:1];
    wire touch;

    assign touch = wr_en || erase_en;
    assign word_a = mem_r[0];
    assign word_b = mem_r[1];

    // Locked store ignores writes and erases; only the refusal pulse moves
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_r[0] <= `NVBL_RST_WORD_A;
            mem_r[1] <= `NVBL_RST_WORD_B;
            refused <= 1'b0;
        end
        else
        begin
            refused <= touch && locked;
            if (touch && !locked)
            begin
                mem_r[idx] <= erase_en ? 24'h000000 : wr_data;
            end
        end
    end
endmodule
`default_nettype wire

//--- nvbl_config_words.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvbl_map.svh"
// Summary of operation
// - Watchdog timeout or halt sets both watchdog error bits in extended error register.
// - With fault recovery at 0, only report the watchdog fault.
// - With fault recovery at 1, report and perform soft restart without store reload.
// - Command 0xFFF8 returns fault recovery, store, processor and idle locks.
// - Store lock at 1 refuses every write and erase of the store.
// - Processor lock at 1 blocks volatile memory and some extended commands.
// - Upper limit steps of 40 gauss; above it sets the over flag.
// - Lower limit steps of 20 gauss; below it sets the under flag.
// - Low sixteen bits load the two filter denominators at initialization.
// - Denominator: bit 15 sign, bit 14 whole, bits 13:0 fraction.
// - Manchester disable at 0 keeps watching the supply for entry.
// - Manchester disable at 1 ignores input after boot; earlier entry still enables.
// - Boot-run at 0 starts idle; run after mode field set to 1.
// - Boot-run at 1 starts directly in run mode.
// - Idle lock refuses return to idle until keycode via command 0xFFFE.
// - Boot-run and idle lock have no writable volatile copy.
module nvbl_config_words
    import nvbl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic nv_wr,
    input wire logic nv_erase,
    input wire logic nv_sel,
    input wire logic [23:0] nv_wdata,
    input wire logic nv_rd,
    input wire logic soft_reset,
    input wire logic boot_done,
    input wire logic wd_fault,
    input wire logic mode_wr,
    input wire logic [1:0] operating_mode_field,
    input wire logic ext_cmd_valid,
    input wire logic [15:0] ext_cmd,
    input wire logic [15:0] ext_data,
    input wire logic [15:0] customer_key,
    input wire logic vram_req,
    input wire logic lim_wr,
    input wire logic [4:0] lim_upper_wdata,
    input wire logic [4:0] lim_lower_wdata,
    input wire logic manch_enter,
    input wire logic [10:0] field_gauss,
    input wire logic field_valid,
    output logic [23:0] nv_rdata,
    output logic nv_refused,
    output logic [1:0] extended_error_reg,
    output logic proc_restart,
    output logic run_mode,
    output logic idle_mode,
    output logic [3:0] lock_status,
    output logic lock_status_valid,
    output logic ext_refused,
    output logic vram_grant,
    output logic manchester_enabled,
    output logic [4:0] volatile_upper_limit,
    output logic [4:0] volatile_lower_limit,
    output logic [15:0] volatile_denominator_b,
    output logic [15:0] volatile_denominator_c,
    output logic field_over_flag,
    output logic field_under_flag
);
    nvbl_state_type state_r;
    nvbl_state_type state_nxt;
    nvbl_word_type word_a;
    nvbl_word_type word_b;
    nvbl_word_type cfg_a_r;
    nvbl_word_type cfg_b_r;
    logic store_refused;
    logic proc_lock_r;
    logic keyed_r;
    logic manch_r;
    logic boot_seen_r;

    ////////////////////////////////////////////////////////////////////////
    // Latched settings and command decode
    wire fault_recovery_sel;
    wire store_write_lock;
    wire idle_entry_lock;
    wire boot_to_run;
    wire manchester_disable;
    wire cmd_locks;
    wire cmd_key;
    wire key_ok;
    wire want_idle;
    wire want_run;
    wire idle_blocked;
    wire proc_cmd;
    wire [3:0] lock_word;

    // Live store bit for locking: a freshly written lock applies at once
    assign store_write_lock = word_a[`NVBL_BIT_LE];
    assign fault_recovery_sel = cfg_a_r[`NVBL_BIT_FR];
    assign boot_to_run = cfg_b_r[`NVBL_BIT_GR];
    assign idle_entry_lock = cfg_b_r[`NVBL_BIT_LI];
    assign manchester_disable = cfg_b_r[`NVBL_BIT_DM];
    assign cmd_locks = ext_cmd_valid && (ext_cmd == `NVBL_CMD_LOCKS);
    assign cmd_key = ext_cmd_valid && (ext_cmd == `NVBL_CMD_KEY);
    assign key_ok = cmd_key && (ext_data == customer_key);
    assign want_idle = mode_wr && (operating_mode_field == 2'h0);
    assign want_run = mode_wr && (operating_mode_field == 2'h1);
    assign idle_blocked = idle_entry_lock && !keyed_r;
    // Commands other than the lock readback and keycode are gated by the processor lock
    assign proc_cmd = ext_cmd_valid && !cmd_locks && !cmd_key;
    assign lock_word = {fault_recovery_sel, cfg_a_r[`NVBL_BIT_LE],
                        proc_lock_r, idle_entry_lock};

    ////////////////////////////////////////////////////////////////////////
    // Store of the two words
    nvbl_word_store u_store
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(nv_wr),
        .erase_en(nv_erase),
        .idx(nv_sel),
        .wr_data(nv_wdata),
        .locked(store_write_lock),
        .word_a(word_a),
        .word_b(word_b),
        .refused(store_refused)
    );

    // Field limit comparison on the volatile limits
    nvbl_field_cmp u_cmp
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .field_gauss(field_gauss),
        .field_valid(field_valid),
        .upper_steps(volatile_upper_limit),
        .lower_steps(volatile_lower_limit),
        .field_over_flag(field_over_flag),
        .field_under_flag(field_under_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer: boot latches the words, load copies them, then idle or run
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            NVBL_BOOT:
            begin
                state_nxt = NVBL_LOAD;
            end
            NVBL_LOAD:
            begin
                // Settings latched in the boot cycle pick the first mode here, before any mode
                state_nxt = boot_to_run ? NVBL_RUN : NVBL_IDLE;
            end
            NVBL_IDLE:
            begin
                if (want_run)
                begin
                    state_nxt = NVBL_RUN;
                end
            end
            NVBL_RUN:
            begin
                if (want_idle && !idle_blocked)
                begin
                    state_nxt = NVBL_IDLE;
                end
            end
            default:
            begin
                state_nxt = NVBL_BOOT;
            end
        endcase
    end

    // Soft restart re-enters boot without re-reading the store
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= NVBL_BOOT;
        end
        else if (soft_reset || (wd_fault && fault_recovery_sel))
        begin
            state_r <= NVBL_BOOT;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Initialization latch of both words into the working copies
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_a_r <= `NVBL_RST_WORD_A;
            cfg_b_r <= `NVBL_RST_WORD_B;
            boot_seen_r <= 1'b0;
        end
        else
        begin
            if (state_r == NVBL_BOOT && !boot_seen_r)
            begin
                cfg_a_r <= word_a;
                cfg_b_r <= word_b;
            end
            if (state_r == NVBL_LOAD)
            begin
                boot_seen_r <= 1'b1; // Later restarts keep the first latch
            end
        end
    end

    // Volatile copies; limits and denominators load at init, limits writable
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            volatile_upper_limit <= 5'h00;
            volatile_lower_limit <= 5'h00;
            volatile_denominator_b <= 16'h0000;
            volatile_denominator_c <= 16'h0000;
            proc_lock_r <= 1'b0;
        end
        else if (state_r == NVBL_LOAD && !boot_seen_r)
        begin
            volatile_upper_limit <= cfg_a_r[`NVBL_LIM_HI:`NVBL_LIM_LO];
            volatile_lower_limit <= cfg_b_r[`NVBL_LIM_HI:`NVBL_LIM_LO];
            // Sign, whole and fraction bits are kept in place, unscaled
            volatile_denominator_b <= cfg_a_r[`NVBL_DEN_HI:0];
            volatile_denominator_c <= cfg_b_r[`NVBL_DEN_HI:0];
            proc_lock_r <= cfg_a_r[`NVBL_BIT_LM];
        end
        else
        begin
            if (lim_wr && !proc_lock_r)
            begin
                volatile_upper_limit <= lim_upper_wdata;
                volatile_lower_limit <= lim_lower_wdata;
            end
            if (key_ok)
            begin
                proc_lock_r <= 1'b0; // The processor lock can be reset by the keycode
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Keycode, watchdog flags and Manchester enable
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            keyed_r <= 1'b0;
            extended_error_reg <= 2'h0;
            proc_restart <= 1'b0;
            manch_r <= 1'b0;
        end
        else
        begin
            if (key_ok)
            begin
                keyed_r <= 1'b1;
            end
            if (wd_fault)
            begin
                extended_error_reg <= 2'h3;
            end
            proc_restart <= wd_fault && fault_recovery_sel;
            // Entry before boot ends always counts; after it only if not disabled
            if (manch_enter && (!boot_seen_r || !manchester_disable))
            begin
                manch_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered answers to the host
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nv_rdata <= 24'h000000;
            nv_refused <= 1'b0;
            lock_status <= 4'h0;
            lock_status_valid <= 1'b0;
            ext_refused <= 1'b0;
            vram_grant <= 1'b0;
            run_mode <= 1'b0;
            idle_mode <= 1'b0;
            manchester_enabled <= 1'b0;
        end
        else
        begin
            if (nv_rd)
            begin
                nv_rdata <= nv_sel ? word_b : word_a;
            end
            nv_refused <= store_refused;
            lock_status_valid <= cmd_locks && boot_seen_r;
            if (cmd_locks && boot_seen_r)
            begin
                lock_status <= lock_word;
            end
            ext_refused <= (proc_cmd && proc_lock_r) || (cmd_key && !key_ok);
            vram_grant <= vram_req && !proc_lock_r;
            run_mode <= state_nxt == NVBL_RUN;
            idle_mode <= state_nxt == NVBL_IDLE;
            manchester_enabled <= manch_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_load;
        state_r == NVBL_LOAD && !soft_reset && !wd_fault;
    endsequence
    sequence s_mode;
        (run_mode == boot_to_run) && (idle_mode == !boot_to_run);
    endsequence

    a_boot_mode_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_load |=> s_mode)
        else $error("boot mode does not follow boot-run bit");
    a_wd_flags_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        wd_fault |=> extended_error_reg == 2'h3)
        else $error("watchdog bits not set");
    a_wd_no_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        wd_fault && !fault_recovery_sel |=> !proc_restart)
        else $error("restart without fault recovery");
    a_wd_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        wd_fault && fault_recovery_sel |=> proc_restart && state_r == NVBL_BOOT)
        else $error("fault recovery did not restart");
    a_lock_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        cmd_locks && boot_seen_r |=> lock_status_valid && lock_status == $past(lock_word))
        else $error("lock readback wrong");
    a_store_locked: assert property (@(posedge sys_clk) disable iff (!rstn)
        (nv_wr || nv_erase) && store_write_lock |=> $stable(word_a) && $stable(word_b))
        else $error("locked store changed");
    a_refuse_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        (nv_wr || nv_erase) && store_write_lock |=> ##1 nv_refused)
        else $error("refusal not reported");
    a_vram_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        vram_req && proc_lock_r && !key_ok |=> !vram_grant)
        else $error("volatile access granted while locked");
    a_idle_lock: assert property (@(posedge sys_clk) disable iff (!rstn)
        state_r == NVBL_RUN && want_idle && idle_blocked && !soft_reset && !wd_fault
        |=> state_r == NVBL_RUN)
        else $error("idle entered while locked");
    a_idle_to_run: assert property (@(posedge sys_clk) disable iff (!rstn)
        state_r == NVBL_IDLE && want_run && !soft_reset && !wd_fault |=> state_r == NVBL_RUN)
        else $error("run not entered from idle");
endmodule
`default_nettype wire

//--- nvbl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvbl_map.svh"
module nvbl_host_model
    import nvbl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [23:0] nv_rdata,
    output logic nv_wr,
    output logic nv_erase,
    output logic nv_sel,
    output logic nv_rd,
    output nvbl_word_type nv_wdata
);
    // Host copy of word A, so the lock bit is known before programming
    nvbl_word_type shadow_a = `NVBL_RST_WORD_A;

    initial
    begin
        nv_wr = 1'b0;
        nv_erase = 1'b0;
        nv_sel = 1'b0;
        nv_rd = 1'b0;
        nv_wdata = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One store access: op 0 write, 1 erase, 2 read; gap makes a slow host
    task automatic access(input logic [1:0] op, input logic sel, input nvbl_word_type data,
        input int gap, output nvbl_word_type rdata);
        repeat (gap) @(posedge sys_clk);
        // Idle lock is never programmed while the store lock reads set
        if (op == 2'h0 && sel && data[`NVBL_BIT_LI] && shadow_a[`NVBL_BIT_LE])
            op = 2'h3;
        @(posedge sys_clk);
        #1;
        nv_sel = sel;
        nv_wdata = data;
        nv_wr = (op == 2'h0);
        nv_erase = (op == 2'h1);
        nv_rd = (op == 2'h2);
        @(posedge sys_clk);
        #1;
        rdata = nv_rdata;
        if (nv_wr && !sel && !shadow_a[`NVBL_BIT_LE])
            shadow_a = data;
        nv_wr = 1'b0;
        nv_erase = 1'b0;
        nv_rd = 1'b0;
        nv_wdata = ~data; // Released data never keeps its last value
    endtask
endmodule
`default_nettype wire

//--- nv_boot_lock_config_words_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvbl_map.svh"
module nv_boot_lock_config_words_tb
    import nvbl_pkg::*;
;
    localparam nvbl_word_type def_a = `NVBL_RST_WORD_A;
    localparam nvbl_word_type def_b = `NVBL_RST_WORD_B;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    wire logic nv_wr, nv_erase, nv_sel, nv_rd;
    wire logic [23:0] nv_wdata;
    logic soft_reset = 1'b0, wd_fault = 1'b0, mode_wr = 1'b0, ext_cmd_valid = 1'b0;
    logic vram_req = 1'b0, lim_wr = 1'b0, manch_enter = 1'b0, field_valid = 1'b0;
    logic boot_done = 1'b0;
    logic [1:0] operating_mode_field = 2'h0;
    logic [15:0] ext_cmd = 16'h0000, ext_data = 16'h0000;
    logic [15:0] customer_key = 16'h5a3c; // Arbitrary keycode
    logic [4:0] lim_upper_wdata = 5'h00, lim_lower_wdata = 5'h00;
    logic [10:0] field_gauss = 11'h000;
    logic [23:0] nv_rdata;
    logic [1:0] extended_error_reg;
    logic [3:0] lock_status;
    logic nv_refused, proc_restart, run_mode, idle_mode, lock_status_valid, ext_refused;
    logic vram_grant, manchester_enabled, field_over_flag, field_under_flag;
    logic [4:0] volatile_upper_limit, volatile_lower_limit;
    logic [15:0] volatile_denominator_b, volatile_denominator_c;
    int num_errors = 0;
    int tests_run = 0;

    // 100 MHz clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    nvbl_config_words DUT (.sys_clk, .rstn, .nv_wr, .nv_erase, .nv_sel,
        .nv_wdata, .nv_rd, .soft_reset, .boot_done, .wd_fault, .mode_wr,
        .operating_mode_field, .ext_cmd_valid, .ext_cmd, .ext_data, .customer_key,
        .vram_req, .lim_wr, .lim_upper_wdata, .lim_lower_wdata, .manch_enter,
        .field_gauss, .field_valid, .nv_rdata, .nv_refused, .extended_error_reg,
        .proc_restart, .run_mode, .idle_mode, .lock_status, .lock_status_valid,
        .ext_refused, .vram_grant, .manchester_enabled, .volatile_upper_limit,
        .volatile_lower_limit, .volatile_denominator_b, .volatile_denominator_c,
        .field_over_flag, .field_under_flag);
    nvbl_host_model host (.sys_clk, .nv_rdata, .nv_wr, .nv_erase, .nv_sel, .nv_rd,
        .nv_wdata);

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers; inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic ext(input logic [15:0] cmd, input logic [15:0] dat);
        step();
        ext_cmd = cmd;
        ext_data = dat;
        ext_cmd_valid = 1'b1;
        step();
        ext_cmd_valid = 1'b0;
    endtask

    function automatic logic over_exp(input logic [10:0] g, input logic [4:0] s);
        return g > s * 11'd40;
    endfunction

    function automatic logic under_exp(input logic [10:0] g, input logic [4:0] s);
        return g < s * 11'd20;
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard far above the length of the test
    initial
    begin
        #500us;
        num_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        nvbl_word_type rd, wb;
        logic [10:0] g;
        int i;
        void'($urandom(32'h2b9fae17));
        repeat (2) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        step();
        step();
        // Erased defaults boot straight to run with fields loaded
        chk("run", run_mode, 1'b1);
        chk("idle", idle_mode, 1'b0);
        chk("upper", volatile_upper_limit, def_a[20:16]);
        chk("lower", volatile_lower_limit, def_b[20:16]);
        chk("den_b", volatile_denominator_b, def_a[15:0]);
        chk("den_c", volatile_denominator_c, def_b[15:0]);
        ext(`NVBL_CMD_LOCKS, 16'h0000);
        chk("lsv", lock_status_valid, 1'b1);
        chk("locks", lock_status, {def_a[23:21], def_b[21]});
        host.access(2'h2, 1'b0, 24'h0, 0, rd);
        chk("word_a", rd, def_a);
        host.access(2'h2, 1'b1, 24'h0, 1, rd);
        chk("word_b", rd, def_b);
        // Random writes while unlocked, both words, prompt and slow host
        for (i = 0; i < 6; i++)
        begin
            wb = $urandom;
            if (i[0] == 1'b0)
                wb = wb & 24'h1fffff;
            host.access(2'h0, i[0], wb, $urandom % 3, rd);
            step();
            chk("no_refuse", nv_refused, 1'b0);
            host.access(2'h2, i[0], 24'h0, 0, rd);
            chk("readback", rd, wb);
        end
        host.access(2'h1, 1'b1, 24'h0, 0, rd);
        host.access(2'h2, 1'b1, 24'h0, 0, rd);
        chk("erased", rd, 24'h000000);
        // Mode field moves between idle and run
        for (i = 0; i < 2; i++)
        begin
            step();
            operating_mode_field = i[1:0];
            mode_wr = 1'b1;
            step();
            mode_wr = 1'b0;
            chk("mode_run", run_mode, i[0]);
            chk("mode_idle", idle_mode, !i[0]);
        end
        // Volatile limits, then field samples with boundary cases first
        step();
        lim_upper_wdata = $urandom % 32;
        lim_lower_wdata = 5'h01 + $urandom % 31;
        lim_wr = 1'b1;
        step();
        lim_wr = 1'b0;
        chk("lim_up", volatile_upper_limit, lim_upper_wdata);
        chk("lim_lo", volatile_lower_limit, lim_lower_wdata);
        for (i = 0; i < 12; i++)
        begin
            g = $urandom % 2048;
            case (i)
                0: g = lim_upper_wdata * 11'd40;
                1: g = lim_upper_wdata * 11'd40 + 11'd1;
                2: g = lim_lower_wdata * 11'd20;
                3: g = lim_lower_wdata * 11'd20 - 11'd1;
                default: ;
            endcase
            step();
            field_gauss = g;
            field_valid = 1'b1;
            step();
            field_valid = 1'b0;
            chk("over", field_over_flag, over_exp(g, lim_upper_wdata));
            chk("under", field_under_flag, under_exp(g, lim_lower_wdata));
        end
        // Manchester entry and volatile access while unlocked
        step();
        manch_enter = 1'b1;
        vram_req = 1'b1;
        step();
        manch_enter = 1'b0;
        step();
        chk("manch", manchester_enabled, 1'b1);
        chk("vram", vram_grant, 1'b1);
        vram_req = 1'b0;
        ext(16'h1234, 16'h0000);
        chk("ext_ok", ext_refused, 1'b0);
        ext(`NVBL_CMD_KEY, customer_key ^ 16'h0001);
        chk("bad_key", ext_refused, 1'b1);
        ext(`NVBL_CMD_KEY, customer_key);
        chk("good_key", ext_refused, 1'b0);
        // Watchdog with recovery off: report only, host restarts the part
        step();
        wd_fault = 1'b1;
        step();
        wd_fault = 1'b0;
        chk("extended_error_reg", extended_error_reg, 2'h3);
        for (i = 0; i < 4; i++)
        begin
            chk("no_restart", proc_restart, 1'b0);
            step();
        end
        soft_reset = 1'b1; // Host takes the corrective action
        step();
        soft_reset = 1'b0;
        step();
        for (i = 0; i < 10 && run_mode !== 1'b1; i++)
            step();
        if (i == 10)
        begin
            num_errors++;
            end_of_test();
        end
        chk("no_reload", volatile_upper_limit, lim_upper_wdata);
        chk("extended_error_reg_kept", extended_error_reg, 2'h3);
        // Store lock takes hold at once; later writes and erases bounce
        host.access(2'h0, 1'b0, def_a | 24'h400000, 0, rd);
        wb = $urandom;
        // Idle lock kept clear so the host really issues this write to the locked store
        wb[`NVBL_BIT_LI] = 1'b0;
        host.access(2'h0, 1'b1, wb, 0, rd);
        step();
        chk("refused", nv_refused, 1'b1);
        host.access(2'h1, 1'b0, 24'h0, 0, rd);
        host.access(2'h2, 1'b1, 24'h0, 0, rd);
        chk("b_kept", rd, def_b & 24'h000000);
        host.access(2'h2, 1'b0, 24'h0, 0, rd);
        chk("a_kept", rd, def_a | 24'h400000);
        chk("run_kept", run_mode, 1'b1);
        // Second reset in mid-run clears outputs and returns the store to its reset defaults
        rstn = 1'b0;
        step();
        chk("rst_extended_error_reg", extended_error_reg, 2'h0);
        chk("rst_run", run_mode, 1'b0);
        rstn = 1'b1;
        step();
        step();
        chk("rerun", run_mode, 1'b1);
        host.access(2'h2, 1'b0, 24'h0, 0, rd);
        chk("re_a", rd, def_a);
        end_of_test();
    end
endmodule
`default_nettype wire
